// File: selector_pkg.sv
// Operation
// - Up to four outputs, one chosen channel each
// - Channel pick clamped to range 1..16
// - Float or 32-bit integer words, whole channels default
// - Field options only with integer input words
// - Packed mode splits words into width-sized fields
// - Sub-field mode extracts picked channel sub-field
// - Each output has its own sub-field pick
// - Packed logic output: field equals picked code
// - Sub-field logic output: sub-field equals target code
// - All picks readable, only widget mode writable
// - Constant-mode channel pick never changes; sub-field ones clamp to the count
// - Scalar-in mode follows scalar input live
// - Param-in mode follows external sequencing source
// - Scalar-out flag drives pick onto output
// - Event flags pulse epoc_valid once per presentation, with epoc_mask
// - Four outputs stored continuously or not at all
// - All picks driven onto one combined link
package selector_pkg;
  // ===
  // Geometry
  localparam int OUTPUTS = 4;
  localparam int PICKS = 8;
  localparam int CHANNELS = 16;
  localparam int WORD_W = 32;
  localparam int PICK_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam logic [PICK_W-1:0] CHAN_MIN = 8'h01;
  localparam logic [PICK_W-1:0] CHAN_MAX = 8'h10;
  localparam logic [PICK_W-1:0] SUB_MIN = 8'h01;
  // ===
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FORMAT = 8'h04;
  localparam logic [7:0] OFS_MODES = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_PICK0 = 8'h10;
  localparam logic [7:0] OFS_PICK7 = 8'h2C;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  localparam logic [7:0] OFS_TARGET = 8'h34;
  // ===
  // Control fields
  localparam int CTRL_FMODE_LSB = 0;
  localparam int CTRL_LOGIC_BIT = 2;
  localparam int CTRL_STORE_BIT = 3;
  localparam int CTRL_INT_BIT = 4;
  localparam logic [1:0] FMODE_WHOLE = 2'h0;
  localparam logic [1:0] FMODE_PACKED = 2'h1;
  localparam logic [1:0] FMODE_SUB = 2'h2;
  localparam int FMT_FW_LSB = 0;
  localparam int FMT_SW_LSB = 8;
  localparam int FMT_CNT_LSB = 16;
  localparam int MODE_W = 4;
  localparam int FLAG_EPOC_LSB = 8;
  // Reset values
  localparam logic [4:0] CTRL_RESET = 5'h10;
  localparam logic [5:0] FW_RESET = 6'h08;
  localparam logic [5:0] SW_RESET = 6'h08;
  localparam logic [4:0] CNT_RESET = 5'h04;
  localparam logic [31:0] MODES_RESET = 32'h1111_1111;
  // ===
  // Pick source modes
  localparam logic [2:0] SRC_CONST = 3'h0;
  localparam logic [2:0] SRC_WIDGET = 3'h1;
  localparam logic [2:0] SRC_PARAM = 3'h2;
  localparam logic [2:0] SRC_SCALAR1 = 3'h3;
  localparam logic [2:0] SRC_SCALAR2 = 3'h4;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Frame sequencer states
  typedef enum logic [2:0] {
    ST_COLLECT = 3'b001,
    ST_LOAD = 3'b010,
    ST_PRESENT = 3'b100
  } seq_state_t;
endpackage : selector_pkg

// File: stream_fifo.sv
`timescale 1ns/100ps
module stream_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // ===
  // Storage and pointers
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg, wr_next;
  logic [AW-1:0] rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rd_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointer and occupancy update
  always_comb begin
    wr_next = push ? wr_reg + AW'(1) : wr_reg;
    rd_next = pop ? rd_reg + AW'(1) : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Registers; memory itself needs no reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end
endmodule : stream_fifo

// File: channel_field_selector.sv
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
module channel_field_selector (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Input stream, one word per channel
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [31:0] in_data,
  input wire logic in_last,
  // Selected outputs
  output logic out_valid,
  input wire logic out_ready,
  output logic [31:0] out_data_0,
  output logic [31:0] out_data_1,
  output logic [31:0] out_data_2,
  output logic [31:0] out_data_3,
  // Stream storage strobe
  output logic selected_wave_store,
  // Pick sources
  input wire logic par_in_valid,
  input wire logic [2:0] par_in_index,
  input wire logic [7:0] par_in_value,
  input wire logic [7:0] scalar_in_1,
  input wire logic [7:0] scalar_in_2,
  // Pick outputs
  output logic [63:0] par_out,
  output logic [63:0] scalar_out,
  output logic epoc_valid,
  output logic [7:0] epoc_mask
);
  localparam int N = selector_pkg::PICKS;
  localparam int PW = selector_pkg::PICK_W;

  // ===
  // Helper functions
  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // Clamp a pick into lo..hi
  function automatic logic [PW-1:0] clamp(input logic [PW-1:0] v, input logic [PW-1:0] lo,
                                          input logic [PW-1:0] hi);
    if (v < lo) begin
      return lo;
    end else if (v > hi) begin
      return hi;
    end
    return v;
  endfunction : clamp

  // Aligned word inside the pick block
  function automatic logic is_pick(input logic [7:0] a);
    return a >= selector_pkg::OFS_PICK0 && a <= selector_pkg::OFS_PICK7 && a[1:0] == 2'h0;
  endfunction : is_pick

  // Field of given width at bit lsb
  function automatic logic [31:0] field_get(input logic [511:0] flat, input logic [9:0] lsb,
                                            input logic [5:0] width);
    logic [511:0] sh;
    logic [32:0] mask;
    sh = flat >> lsb;
    mask = (width >= 6'h20) ? 33'h0_FFFF_FFFF : ((33'h1 << width) - 33'h1);
    return sh[31:0] & mask[31:0];
  endfunction : field_get

  // ===
  // Register state
  logic [4:0] ctrl_reg, ctrl_next;
  logic [5:0] fw_reg, fw_next;
  logic [5:0] sw_reg, sw_next;
  logic [4:0] subfield_count_reg, subfield_count_next;
  logic [31:0] modes_reg, modes_next;
  logic [15:0] flags_reg, flags_next;
  logic [PW-1:0] widget_reg [N];
  logic [PW-1:0] widget_next [N];
  logic [PW-1:0] target_reg, target_next;
  // AXI handshake state
  logic [7:0] awaddr_reg, awaddr_next;
  logic aw_got_reg, aw_got_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic w_got_reg, w_got_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  // Pick state
  logic [PW-1:0] parin_reg [N];
  logic [PW-1:0] parin_next [N];
  logic [PW-1:0] pick_reg [N];
  logic [PW-1:0] pick_next [N];
  // Frame sequencer state
  selector_pkg::seq_state_t state_reg, state_next;
  logic [31:0] frame_mem [selector_pkg::CHANNELS];
  logic [3:0] widx_reg, widx_next;
  logic [15:0] frames_reg, frames_next;
  logic [31:0] odata_reg [selector_pkg::OUTPUTS];
  logic [31:0] odata_next [selector_pkg::OUTPUTS];
  logic ovalid_reg, ovalid_next;
  logic store_reg, store_next;
  logic epoc_reg, epoc_next;
  // FIFO drain side
  logic f_valid, f_ready;
  logic [32:0] f_data;

  // ===
  // Input buffer; a full FIFO stalls the source
  stream_fifo #(
    .WIDTH(33),
    .DEPTH(selector_pkg::FIFO_DEPTH)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data({in_last, in_data}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // ===
  // Register bus and register file
  always_comb begin
    logic [31:0] w;
    logic [2:0] idx;
    w = '0;
    idx = '0;
    ctrl_next = ctrl_reg;
    fw_next = fw_reg;
    sw_next = sw_reg;
    subfield_count_next = subfield_count_reg;
    modes_next = modes_reg;
    flags_next = flags_reg;
    target_next = target_reg;
    widget_next = widget_reg;
    awaddr_next = awaddr_reg;
    aw_got_next = aw_got_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    w_got_next = w_got_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    // Address and data are taken independently, in either order
    if (s_axi_awvalid && awready_reg) begin
      awaddr_next = s_axi_awaddr;
      aw_got_next = 1'b1;
    end
    if (s_axi_wvalid && wready_reg) begin
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
      w_got_next = 1'b1;
    end
    // Response retires first, then the next write may land
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (aw_got_reg && w_got_reg && !bvalid_reg) begin
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = selector_pkg::RESP_OKAY;
      idx = 3'((awaddr_reg - selector_pkg::OFS_PICK0) >> 2);
      if (awaddr_reg == selector_pkg::OFS_CTRL) begin
        w = merge({27'h0, ctrl_reg}, wdata_reg, wstrb_reg);
        ctrl_next = w[4:0];
      end else if (awaddr_reg == selector_pkg::OFS_FORMAT) begin
        w = merge({11'h0, subfield_count_reg, 2'h0, sw_reg, 2'h0, fw_reg}, wdata_reg, wstrb_reg);
        fw_next = w[selector_pkg::FMT_FW_LSB +: 6];
        sw_next = w[selector_pkg::FMT_SW_LSB +: 6];
        subfield_count_next = w[selector_pkg::FMT_CNT_LSB +: 5];
      end else if (awaddr_reg == selector_pkg::OFS_MODES) begin
        modes_next = merge(modes_reg, wdata_reg, wstrb_reg);
      end else if (awaddr_reg == selector_pkg::OFS_FLAGS) begin
        w = merge({16'h0, flags_reg}, wdata_reg, wstrb_reg);
        flags_next = w[15:0];
      end else if (is_pick(awaddr_reg)) begin
        // Only widget-mode picks take writes; others keep their value
        if (modes_reg[idx*selector_pkg::MODE_W +: 3] == selector_pkg::SRC_WIDGET
            && wstrb_reg[0]) begin
          widget_next[idx] = wdata_reg[PW-1:0];
        end
      end else if (awaddr_reg == selector_pkg::OFS_TARGET) begin
        w = merge({24'h0, target_reg}, wdata_reg, wstrb_reg);
        target_next = w[PW-1:0];
      end else if (awaddr_reg != selector_pkg::OFS_STATUS) begin
        bresp_next = selector_pkg::RESP_SLVERR;
      end
    end
    // Read: answer one cycle after the address is taken
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next = selector_pkg::RESP_OKAY;
      rdata_next = '0;
      idx = 3'((s_axi_araddr - selector_pkg::OFS_PICK0) >> 2);
      if (s_axi_araddr == selector_pkg::OFS_CTRL) begin
        rdata_next = {27'h0, ctrl_reg};
      end else if (s_axi_araddr == selector_pkg::OFS_FORMAT) begin
        rdata_next = {11'h0, subfield_count_reg, 2'h0, sw_reg, 2'h0, fw_reg};
      end else if (s_axi_araddr == selector_pkg::OFS_MODES) begin
        rdata_next = modes_reg;
      end else if (s_axi_araddr == selector_pkg::OFS_FLAGS) begin
        rdata_next = {16'h0, flags_reg};
      end else if (is_pick(s_axi_araddr)) begin
        rdata_next = {24'h0, pick_reg[idx]};
      end else if (s_axi_araddr == selector_pkg::OFS_STATUS) begin
        rdata_next = {frames_reg, 13'h0, state_reg};
      end else if (s_axi_araddr == selector_pkg::OFS_TARGET) begin
        rdata_next = {24'h0, target_reg};
      end else begin
        rresp_next = selector_pkg::RESP_SLVERR;
      end
    end
    // Ready flags follow the next-cycle state
    awready_next = ~aw_got_next;
    wready_next = ~w_got_next;
    arready_next = ~rvalid_next;
  end

  // Bus and configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= selector_pkg::CTRL_RESET;
      fw_reg <= selector_pkg::FW_RESET;
      sw_reg <= selector_pkg::SW_RESET;
      subfield_count_reg <= selector_pkg::CNT_RESET;
      modes_reg <= selector_pkg::MODES_RESET;
      flags_reg <= '0;
      target_reg <= '0;
      for (int i = 0; i < N; i++) begin
        widget_reg[i] <= selector_pkg::CHAN_MIN;
      end
      awaddr_reg <= '0;
      aw_got_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      w_got_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= selector_pkg::RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= selector_pkg::RESP_OKAY;
    end else begin
      ctrl_reg <= ctrl_next;
      fw_reg <= fw_next;
      sw_reg <= sw_next;
      subfield_count_reg <= subfield_count_next;
      modes_reg <= modes_next;
      flags_reg <= flags_next;
      target_reg <= target_next;
      widget_reg <= widget_next;
      awaddr_reg <= awaddr_next;
      aw_got_reg <= aw_got_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      w_got_reg <= w_got_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // ===
  // Picks 0..3 choose channels, 4..7 choose sub-fields
  always_comb begin
    logic [PW-1:0] raw;
    logic [PW-1:0] hi;
    raw = '0;
    hi = '0;
    parin_next = parin_reg;
    if (par_in_valid) begin
      parin_next[par_in_index] = par_in_value;
    end
    for (int i = 0; i < N; i++) begin
      case (modes_reg[i*selector_pkg::MODE_W +: 3])
        selector_pkg::SRC_WIDGET: raw = widget_reg[i];
        selector_pkg::SRC_PARAM: raw = parin_reg[i];
        selector_pkg::SRC_SCALAR1: raw = scalar_in_1;
        selector_pkg::SRC_SCALAR2: raw = scalar_in_2;
        // Constant picks sit at their own position
        default: raw = PW'(i % selector_pkg::OUTPUTS + 1);
      endcase
      // Sub-field picks are bounded by the configured count
      hi = (i < selector_pkg::OUTPUTS) ? selector_pkg::CHAN_MAX : PW'(subfield_count_reg);
      pick_next[i] = clamp(raw, (i < selector_pkg::OUTPUTS) ? selector_pkg::CHAN_MIN
                                 : selector_pkg::SUB_MIN, hi);
    end
  end

  // Pick registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < N; i++) begin
        parin_reg[i] <= selector_pkg::CHAN_MIN;
        pick_reg[i] <= selector_pkg::CHAN_MIN;
      end
    end else begin
      parin_reg <= parin_next;
      pick_reg <= pick_next;
    end
  end

  // ===
  // Frame sequencer and field extraction
  always_comb begin
    logic [511:0] flat;
    logic [1:0] fmode;
    logic [PW-1:0] ch;
    logic [PW-1:0] sub;
    logic [31:0] val;
    flat = '0;
    fmode = ctrl_reg[selector_pkg::CTRL_FMODE_LSB +: 2];
    ch = '0;
    sub = '0;
    val = '0;
    state_next = state_reg;
    widx_next = widx_reg;
    frames_next = frames_reg;
    odata_next = odata_reg;
    ovalid_next = ovalid_reg;
    store_next = 1'b0;
    epoc_next = 1'b0;
    f_ready = 1'b0;
    // Float input forces whole channels
    if (!ctrl_reg[selector_pkg::CTRL_INT_BIT]) begin
      fmode = selector_pkg::FMODE_WHOLE;
    end
    // Fields count upward from the low bits of the first word
    for (int c = 0; c < selector_pkg::CHANNELS; c++) begin
      flat[c*selector_pkg::WORD_W +: selector_pkg::WORD_W] = frame_mem[c];
    end
    case (state_reg)
      selector_pkg::ST_COLLECT: begin
        // Draining stalls outside this state, so the FIFO backs up
        f_ready = 1'b1;
        if (f_valid) begin
          widx_next = widx_reg + 4'h1;
          if (f_data[32] || widx_reg == 4'hF) begin
            widx_next = '0;
            state_next = selector_pkg::ST_LOAD;
          end
        end
      end
      selector_pkg::ST_LOAD: begin
        for (int o = 0; o < selector_pkg::OUTPUTS; o++) begin
          ch = pick_reg[o] - 8'h01;
          sub = pick_reg[o + selector_pkg::OUTPUTS] - 8'h01;
          if (fmode == selector_pkg::FMODE_PACKED) begin
            val = field_get(flat, 10'(ch) * 10'(fw_reg), fw_reg);
            if (ctrl_reg[selector_pkg::CTRL_LOGIC_BIT]) begin
              val = {31'h0, val == 32'(pick_reg[o + selector_pkg::OUTPUTS])};
            end
          end else if (fmode == selector_pkg::FMODE_SUB) begin
            val = field_get(flat, 10'(ch) * 10'(selector_pkg::WORD_W) + 10'(sub) * 10'(sw_reg),
                            sw_reg);
            if (ctrl_reg[selector_pkg::CTRL_LOGIC_BIT]) begin
              val = {31'h0, val == 32'(target_reg)};
            end
          end else begin
            val = frame_mem[ch[3:0]];
          end
          odata_next[o] = val;
        end
        ovalid_next = 1'b1;
        frames_next = frames_reg + 16'h0001;
        store_next = ctrl_reg[selector_pkg::CTRL_STORE_BIT];
        epoc_next = |flags_reg[selector_pkg::FLAG_EPOC_LSB +: N];
        state_next = selector_pkg::ST_PRESENT;
      end
      selector_pkg::ST_PRESENT: begin
        if (out_ready) begin
          ovalid_next = 1'b0;
          state_next = selector_pkg::ST_COLLECT;
        end
      end
      default: begin
        state_next = selector_pkg::ST_COLLECT;
      end
    endcase
  end

  // Sequencer registers and frame store
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= selector_pkg::ST_COLLECT;
      widx_reg <= '0;
      frames_reg <= '0;
      ovalid_reg <= 1'b0;
      store_reg <= 1'b0;
      epoc_reg <= 1'b0;
      for (int o = 0; o < selector_pkg::OUTPUTS; o++) begin
        odata_reg[o] <= '0;
      end
    end else begin
      state_reg <= state_next;
      widx_reg <= widx_next;
      frames_reg <= frames_next;
      ovalid_reg <= ovalid_next;
      store_reg <= store_next;
      epoc_reg <= epoc_next;
      odata_reg <= odata_next;
    end
    if (f_valid && f_ready) begin
      frame_mem[widx_reg] <= f_data[31:0];
    end
  end

  // ===
  // Output drive
  always_comb begin
    s_axi_awready = awready_reg;
    s_axi_wready = wready_reg;
    s_axi_bvalid = bvalid_reg;
    s_axi_bresp = bresp_reg;
    s_axi_arready = arready_reg;
    s_axi_rvalid = rvalid_reg;
    s_axi_rdata = rdata_reg;
    s_axi_rresp = rresp_reg;
    out_valid = ovalid_reg;
    out_data_0 = odata_reg[0];
    out_data_1 = odata_reg[1];
    out_data_2 = odata_reg[2];
    out_data_3 = odata_reg[3];
    selected_wave_store = store_reg;
    epoc_valid = epoc_reg;
    epoc_mask = flags_reg[selector_pkg::FLAG_EPOC_LSB +: N];
    for (int i = 0; i < N; i++) begin
      par_out[i*PW +: PW] = pick_reg[i];
      scalar_out[i*PW +: PW] = flags_reg[i] ? pick_reg[i] : '0;
    end
  end
endmodule : channel_field_selector

// File: selector_asserts.sv
`timescale 1ns/100ps
module selector_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus answers
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Stream and picks
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [31:0] out_data_0,
  input wire logic selected_wave_store,
  input wire logic epoc_valid,
  input wire logic [7:0] epoc_mask,
  input wire logic [63:0] par_out,
  input wire logic [63:0] scalar_out
);
  // ===
  // One domain, so one clock and one disable
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_OUT_HOLD: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data_0)) else $error("output not held");
  AST_PICK_RANGE: assert property (
    par_out[7:0] inside {[8'h01:8'h10]}) else $error("channel pick out of range");
  AST_STORE_ONCE: assert property (
    selected_wave_store |=> !selected_wave_store) else $error("store strobe too long");
  AST_STORE_FRAME: assert property (
    selected_wave_store |-> $rose(out_valid)) else $error("store strobe without frame");
  AST_EPOC_FRAME: assert property (
    epoc_valid |-> $rose(out_valid) && epoc_mask != 8'h00) else $error("bad event strobe");
  AST_SCOUT: assert property (
    scalar_out[7:0] == 8'h00 || scalar_out[7:0] == par_out[7:0]) else $error("scalar out wrong");
  AST_B_DONE: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write answer repeated");
  AST_R_DONE: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read answer repeated");
  AST_AR_BUSY: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
endmodule : selector_asserts

bind channel_field_selector selector_asserts i_selector_asserts (.*);

// File: stream_source.sv
`timescale 1ns/100ps
module stream_source (
  // Clock
  input wire logic aclk,
  // Words into the selector
  output logic in_valid,
  input wire logic in_ready,
  output logic [31:0] in_data,
  output logic in_last,
  // Selected outputs
  input wire logic out_valid,
  output logic out_ready,
  input wire logic slow
);
  int w = 0;
  initial begin
    in_valid = 1'b0;
    in_last = 1'b0;
    in_data = 32'h0;
  end
  // Sink takes frames at once, or late when slow
  always @(posedge aclk) begin
    w <= out_valid ? w + 1 : 0;
    out_ready <= out_valid && !out_ready && w >= (slow ? 3 : 0);
  end
  // Four words, held until taken; data scrambled once released
  task automatic send(input logic [127:0] f);
    for (int k = 0; k < 4; k++) begin
      in_valid <= 1'b1;
      in_data <= f[32 * k +: 32];
      in_last <= (k == 3);
      do @(posedge aclk); while (!in_ready);
    end
    in_valid <= 1'b0;
    in_data <= ~in_data;
    in_last <= 1'b0;
  endtask : send
endmodule : stream_source

// File: channel_field_selector_tb.sv
`timescale 1ns/100ps
module channel_field_selector_tb;
  // ===
  // Signals named as the ports
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, par_in_valid = 0, slow = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, in_valid;
  logic in_ready, in_last, out_valid, out_ready, selected_wave_store, epoc_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0] par_in_index = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, par_in_value = 8'h00, epoc_mask;
  logic [7:0] scalar_in_1 = 8'h00, scalar_in_2 = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, in_data, rdv;
  logic [31:0] out_data_0, out_data_1, out_data_2, out_data_3;
  logic [63:0] par_out, scalar_out;
  logic [127:0] got;
  // Frame word k carries bytes 4k+1..4k+4, so field n reads n
  localparam logic [127:0] W = 128'h100F0E0D_0C0B0A09_08070605_04030201;
  int n_errors = 0, samples_checked = 0, cyc = 0, n_frames = 0, n_store = 0, n_epoc = 0;
  typedef struct packed { logic [7:0] ctrl; logic [63:0] picks; logic [127:0] exp; } row_t;
  // Whole, packed, packed logic, sub-field, sub-field logic, float forced whole
  row_t rows [6] = '{
    '{8'h10, 64'h01010101_04030201, W},
    '{8'h19, 64'h01010101_100B0601, 128'h00000010_0000000B_00000006_00000001},
    '{8'h1D, 64'h02030301_04030201, 128'h00000000_00000001_00000000_00000001},
    '{8'h1A, 64'h03020401_04010302, 128'h0000000F_00000002_0000000C_00000005},
    '{8'h1E, 64'h03020401_04010302, 128'h00000000_00000000_00000001_00000000},
    '{8'h05, 64'h01010101_04030201, W}};
  channel_field_selector i_channel_field_selector (.*);
  stream_source i_stream_source (.*);
  always #2 aclk = ~aclk;
  // Frame capture, strobe counts and the hang limit
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (out_valid && out_ready) begin
      got <= {out_data_3, out_data_2, out_data_1, out_data_0};
      n_frames <= n_frames + 1;
    end
    n_store <= n_store + selected_wave_store;
    n_epoc <= n_epoc + epoc_valid;
    if (cyc == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Leading edge avoids two drives in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rsp = s_axi_rresp;
    rdv = s_axi_rdata;
  endtask : rd
  task automatic send_frame();
    int f;
    f = n_frames;
    i_stream_source.send(W);
    for (int t = 0; t < 200 && n_frames == f; t++) @(posedge aclk);
    @(posedge aclk);
  endtask : send_frame
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  // Reset for n cycles, then picks must read 1
  task automatic reset_for(input int n);
    aresetn <= 1'b0;
    repeat (n) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("reset picks", par_out, 64'h01010101_01010101);
  endtask : reset_for
  initial begin
    reset_for(6);
    rd(8'h08);
    chk("reset modes", rdv, 32'h11111111);
    wr(8'h34, 32'h0000000C);
    foreach (rows[r]) begin
      wr(8'h00, {24'h0, rows[r].ctrl});
      for (int i = 0; i < 8; i++) wr(8'h10 + 8'(4 * i), {24'h0, rows[r].picks[8 * i +: 8]});
      send_frame();
      chk("row outputs", got, rows[r].exp);
      $display("row %0d done", r);
    end
    chk("store pulses", n_store, 4);
    wr(8'h10, 32'h00000014);
    rd(8'h10);
    chk("clamped pick", rdv, 32'h00000010);
    rd(8'h40);
    chk("unmapped read", rsp, 2'h2);
    wr(8'h40, 32'h0);
    chk("unmapped write", rsp, 2'h2);
    // Pick 0 constant, 1 and 2 scalar, 3 from the sequencer
    wr(8'h08, 32'h11112430);
    scalar_in_1 <= 8'h07;
    scalar_in_2 <= 8'h09;
    par_in_index <= 3'h3;
    par_in_value <= 8'h05;
    par_in_valid <= 1'b1;
    @(posedge aclk);
    par_in_valid <= 1'b0;
    wr(8'h10, 32'h00000005);
    wr(8'h0C, 32'h00000101);
    repeat (3) @(posedge aclk);
    chk("live picks", par_out[31:0], 32'h05090701);
    chk("scalar out", scalar_out[7:0], 8'h01);
    slow <= 1'b1;
    send_frame();
    chk("event pulses", n_epoc, 1);
    reset_for(2);
    $display("source, event and reset tests done");
    tally_and_finish();
  end
endmodule : channel_field_selector_tb
